// File: ivm_regs.vh
// Constants for the interrupt vector mapping block.
`ifndef IVM_REGS_VH
`define IVM_REGS_VH
`define IVM_CORE_VEC_LO      8'h00
`define IVM_CORE_VEC_HI      8'h3c
`define IVM_USER_VEC_LO      8'h40
`define IVM_USER_VEC_HI      8'hbc
`define IVM_NUM_USER         32
`define IVM_POS_GPIO         5'h00
`define IVM_POS_FLASH        5'h01
`define IVM_POS_UART         5'h04
`define IVM_POS_SPI          5'h05
`define IVM_POS_RADIO        5'h06
`define IVM_POS_WDOG         5'h07
`define IVM_POS_ADC          5'h0d
`define IVM_POS_I2C2         5'h0e
`define IVM_POS_I2C1         5'h0f
`define IVM_POS_TMR1A        5'h11
`define IVM_POS_TMR1B        5'h12
`define IVM_POS_TMR2A        5'h13
`define IVM_POS_TMR2B        5'h14
`define IVM_POS_RTC          5'h15
`define IVM_POS_CRYPTO       5'h16
`define IVM_POS_DMA          5'h17
`define IVM_USED_MASK        32'h00fee0f3
`define IVM_EXC_RESET        4'h1
`define IVM_EXC_NMI          4'h2
`define IVM_EXC_HARD_FAULT   4'h3
`define IVM_EXC_SVC          4'hb
`define IVM_EXC_PENDABLE_SERVICE_EXCEPTION       4'he
`define IVM_EXC_SYSTICK      4'hf
`define IVM_PRIO_RESET       3'h0
`define IVM_PRIO_NMI         3'h1
`define IVM_PRIO_HARD_FAULT  3'h2
`define IVM_PRIO_RESET_VAL   2'h0
`endif

// File: ivm_sync.v
// Two-stage synchroniser for one asynchronous input line.
`timescale 1ns/10ps
`default_nettype none
module ivm_sync
(
  input  wire ref_clk,
  input  wire resetn,
  input  wire clk_en,
  input  wire async_in,
  output wire sync_out
);
  reg stage_a;
  reg stage_b;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
    end
    else if (clk_en)
    begin
      stage_a <= async_in;
      stage_b <= stage_a;
    end
  end

  assign sync_out = stage_b;
endmodule
`default_nettype wire

// File: ivm_interrupt_vector_mapping.v
// Interrupt vector mapping: routes peripheral requests and core exceptions to vectors.
// What this block does
// - Vector addresses 0x00 to 0x3C belong to the core's own exceptions.
// - Thirty-two user lines take consecutive word vectors 0x40 through 0xBC.
// - Sixteen of the user lines are each fed by one peripheral; the other sixteen positions stay inactive.
// - Reset, non-maskable and hard fault have fixed priorities; hard fault is 2.
`timescale 1ns/10ps
`default_nettype none
`include "ivm_regs.vh"
module ivm_interrupt_vector_mapping
#(
  parameter NUM_USER = `IVM_NUM_USER
)
(
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        clk_en,
  input  wire        gpio_irq,
  input  wire        flash_irq,
  input  wire        uart_irq,
  input  wire        spi_irq,
  input  wire        radio_irq,
  input  wire        watchdog_irq,
  input  wire        adc_irq,
  input  wire        i2c2_irq,
  input  wire        i2c1_irq,
  input  wire        multifunction_timer_one_a_irq,
  input  wire        multifunction_timer_one_b_irq,
  input  wire        multifunction_timer_two_a_irq,
  input  wire        multifunction_timer_two_b_irq,
  input  wire        rtc_irq,
  input  wire        public_key_accelerator_irq,
  input  wire        dma_irq,
  input  wire        reset_req,
  input  wire        nmi_req,
  input  wire        hard_fault_req,
  input  wire        supervisor_call_req,
  input  wire        pendable_service_req,
  input  wire        system_timer_req,
  input  wire        prio_wr,
  input  wire [4:0]  prio_wr_pos,
  input  wire [1:0]  prio_wr_data,
  input  wire [1:0]  svc_prio,
  input  wire [1:0]  pendable_service_exception_prio,
  input  wire [1:0]  systick_prio,
  output reg  [31:0] user_pending,
  output reg         vector_valid,
  output reg  [7:0]  vector_addr,
  output reg         vector_critical,
  output reg  [63:0] user_prio
);
  wire [31:0] raw_lines;
  wire [31:0] sync_lines;
  reg  [31:0] next_pending;
  reg         next_valid;
  reg  [7:0]  next_addr;
  reg         next_critical;
  reg  [2:0]  best_prio;
  reg  [2:0]  cand_prio;
  wire [2:0]  svc_level;
  wire [2:0]  pendable_service_exception_level;
  wire [2:0]  systick_level;
  reg         user_hit;
  reg  [7:0]  user_addr;
  reg         user_crit;
  reg  [2:0]  user_best;
  integer     i;

  ////////////////////////////////////////////////////////////////////////////////
  // peripheral line wiring
  assign raw_lines = {8'h00,
                      dma_irq,
                      public_key_accelerator_irq,
                      rtc_irq,
                      multifunction_timer_two_b_irq,
                      multifunction_timer_two_a_irq,
                      multifunction_timer_one_b_irq,
                      multifunction_timer_one_a_irq,
                      1'b0,
                      i2c1_irq,
                      i2c2_irq,
                      adc_irq,
                      5'h00,
                      watchdog_irq,
                      radio_irq,
                      spi_irq,
                      uart_irq,
                      2'h0,
                      flash_irq,
                      gpio_irq};

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : gen_sync
      ivm_sync u_sync
      (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (raw_lines[g]),
        .sync_out (sync_lines[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // settable levels below fixed
  assign svc_level = {1'b0, svc_prio} + 3'h3;
  assign pendable_service_exception_level = {1'b0, pendable_service_exception_prio} + 3'h3;
  assign systick_level = {1'b0, systick_prio} + 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    next_pending = sync_lines & `IVM_USED_MASK;
    user_hit = 1'b0;
    user_addr = 8'h00;
    user_crit = 1'b0;
    user_best = 3'h7;
    cand_prio = 3'h7;
    for (i = 0; i < NUM_USER; i = i + 1)
    begin
      cand_prio = {1'b0, user_prio[2*i +: 2]} + 3'h3;
      if (next_pending[i] && (cand_prio < user_best))
      begin
        user_hit = 1'b1;
        user_addr = `IVM_USER_VEC_LO + {1'b0, i[4:0], 2'h0};
        user_crit = (i[4:0] == `IVM_POS_RADIO);
        user_best = cand_prio;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    next_valid = 1'b0;
    next_addr = 8'h00;
    next_critical = 1'b0;
    best_prio = 3'h7;
    if (reset_req)
    begin
      next_valid = 1'b1;
      next_addr = {2'h0, `IVM_EXC_RESET, 2'h0};
      best_prio = `IVM_PRIO_RESET;
    end
    else if (nmi_req)
    begin
      next_valid = 1'b1;
      next_addr = {2'h0, `IVM_EXC_NMI, 2'h0};
      best_prio = `IVM_PRIO_NMI;
    end
    else if (hard_fault_req)
    begin
      next_valid = 1'b1;
      next_addr = {2'h0, `IVM_EXC_HARD_FAULT, 2'h0};
      best_prio = `IVM_PRIO_HARD_FAULT;
    end
    else
    begin
      if (supervisor_call_req && (svc_level < best_prio))
      begin
        next_valid = 1'b1;
        next_addr = {2'h0, `IVM_EXC_SVC, 2'h0};
        best_prio = svc_level;
      end
      if (pendable_service_req && (pendable_service_exception_level < best_prio))
      begin
        next_valid = 1'b1;
        next_addr = {2'h0, `IVM_EXC_PENDABLE_SERVICE_EXCEPTION, 2'h0};
        best_prio = pendable_service_exception_level;
      end
      if (system_timer_req && (systick_level < best_prio))
      begin
        next_valid = 1'b1;
        next_addr = {2'h0, `IVM_EXC_SYSTICK, 2'h0};
        best_prio = systick_level;
      end
      if (user_hit && (user_best < best_prio))
      begin
        next_valid = 1'b1;
        next_addr = user_addr;
        next_critical = user_crit;
        best_prio = user_best;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      user_pending <= 32'h00000000;
      vector_valid <= 1'b0;
      vector_addr <= 8'h00;
      vector_critical <= 1'b0;
    end
    else if (clk_en)
    begin
      user_pending <= next_pending;
      vector_valid <= next_valid;
      vector_addr <= next_addr;
      vector_critical <= next_critical;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      user_prio <= {32{`IVM_PRIO_RESET_VAL}};
    end
    else if (clk_en && prio_wr)
    begin
      user_prio[{prio_wr_pos, 1'b0} +: 2] <= prio_wr_data;
    end
  end
endmodule
`default_nettype wire

// File: ivm_src.sv
// Model of the peripherals that raise the user interrupt lines.
`timescale 1ns/10ps
`default_nettype none
module ivm_src
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] want,
  output var  logic [15:0] irq
);
  initial irq = 16'h0;
  always @(posedge ref_clk)
    irq <= want;
endmodule
`default_nettype wire

// File: ivm_props.sv
// Checker for the interrupt vector mapping block.
`timescale 1ns/10ps
`default_nettype none
module ivm_props
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        reset_req,
  input wire logic        nmi_req,
  input wire logic        hard_fault_req,
  input wire logic        prio_wr,
  input wire logic [4:0]  prio_wr_pos,
  input wire logic [1:0]  prio_wr_data,
  input wire logic [31:0] user_pending,
  input wire logic        vector_valid,
  input wire logic [7:0]  vector_addr,
  input wire logic        vector_critical,
  input wire logic [63:0] user_prio
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  resv_quiet_a: assert property ((user_pending & ~32'h00fee0f3) == 32'h0)
    else $error("reserved line pending");
  reset_first_a: assert property (clk_en && reset_req |=> vector_valid && vector_addr == 8'h04)
    else $error("reset vector lost");
  fault_next_a: assert property (clk_en && hard_fault_req && !reset_req && !nmi_req |=>
    vector_addr == 8'h0c) else $error("fault vector lost");
  addr_word_a: assert property (vector_valid |-> vector_addr[1:0] == 2'h0 &&
    vector_addr <= 8'hbc && vector_addr != 8'h00) else $error("vector out of table");
  crit_flag_a: assert property (vector_critical == (vector_valid && vector_addr == 8'h58))
    else $error("critical flag wrong");
  prio_store_a: assert property (clk_en && prio_wr |=>
    user_prio[2*$past(prio_wr_pos) +: 2] == $past(prio_wr_data)) else $error("prio not stored");
endmodule
bind ivm_interrupt_vector_mapping ivm_props u_props (.ref_clk(ref_clk), .resetn(resetn),
  .clk_en(clk_en), .reset_req(reset_req), .nmi_req(nmi_req), .hard_fault_req(hard_fault_req),
  .prio_wr(prio_wr), .prio_wr_pos(prio_wr_pos), .prio_wr_data(prio_wr_data),
  .user_pending(user_pending), .vector_valid(vector_valid), .vector_addr(vector_addr),
  .vector_critical(vector_critical), .user_prio(user_prio));
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the interrupt vector mapping block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] want = 16'h0;
  logic [15:0] irq;
  logic        rst_q = 1'b0, nmi_q = 1'b0, hf_q = 1'b0, svc_q = 1'b0, psv_q = 1'b0;
  logic        prio_wr = 1'b0;
  logic        sys_q = 1'b0, run = 1'b1;
  logic [4:0]  prio_wr_pos = 5'h00;
  logic [1:0]  prio_wr_data = 2'h0;
  wire  [31:0] pend;
  wire         vld, crit;
  wire  [7:0]  addr;
  wire  [63:0] prio;
  int          num_errors = 0;
  int          tests_run = 0;
  logic [4:0]  pos_tab [16] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0d, 5'h0e,
                                5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
  always #25 ref_clk = ~ref_clk;
  ivm_src u_src (.ref_clk(ref_clk), .want(want), .irq(irq));
  ivm_interrupt_vector_mapping dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(run),
    .gpio_irq(irq[0]), .flash_irq(irq[1]), .uart_irq(irq[2]), .spi_irq(irq[3]),
    .radio_irq(irq[4]), .watchdog_irq(irq[5]), .adc_irq(irq[6]), .i2c2_irq(irq[7]),
    .i2c1_irq(irq[8]), .multifunction_timer_one_a_irq(irq[9]),
    .multifunction_timer_one_b_irq(irq[10]), .multifunction_timer_two_a_irq(irq[11]),
    .multifunction_timer_two_b_irq(irq[12]), .rtc_irq(irq[13]),
    .public_key_accelerator_irq(irq[14]), .dma_irq(irq[15]), .reset_req(rst_q),
    .nmi_req(nmi_q), .hard_fault_req(hf_q), .supervisor_call_req(svc_q),
    .pendable_service_req(psv_q), .system_timer_req(sys_q), .prio_wr(prio_wr),
    .prio_wr_pos(prio_wr_pos), .prio_wr_data(prio_wr_data), .svc_prio(2'h0), .pendable_service_exception_prio(2'h0),
    .systick_prio(2'h0), .user_pending(pend), .vector_valid(vld), .vector_addr(addr),
    .vector_critical(crit), .user_prio(prio));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_map;
    for (int k = 0; k < 16; k++)
    begin
      @(posedge ref_clk);
      want <= 16'h1 << k;
      cyc(6);
      check(pend, 32'h1 << pos_tab[k]);
      check(addr, 8'h40 + {pos_tab[k], 2'b00});
      check(crit, pos_tab[k] == 5'h06);
      check(vld, 1'b1);
    end
    @(posedge ref_clk);
    want <= 16'h0;
    cyc(6);
    check(vld, 1'b0);
  endtask
  task automatic t_prio;
    @(posedge ref_clk);
    prio_wr <= 1'b1;
    prio_wr_data <= 2'h3;
    want <= 16'h0005;
    @(posedge ref_clk);
    prio_wr <= 1'b0;
    cyc(6);
    check(prio, 64'h3);
    check(addr, 8'h50);
    @(posedge ref_clk);
    prio_wr <= 1'b1;
    prio_wr_pos <= 5'h04;
    @(posedge ref_clk);
    prio_wr <= 1'b0;
    cyc(2);
    check(prio, 64'h303);
    check(addr, 8'h40);
  endtask
  task automatic t_hold;
    @(posedge ref_clk);
    run <= 1'b0;
    want <= 16'h0010;
    cyc(6);
    check(pend, 32'h0);
    @(posedge ref_clk);
    run <= 1'b1;
    cyc(6);
    check(pend, 32'h1 << 6);
    check(crit, 1'b1);
  endtask
  task automatic t_core;
    @(posedge ref_clk);
    sys_q <= 1'b1;
    cyc(2);
    check(addr, 8'h3c);
    @(posedge ref_clk);
    svc_q <= 1'b1;
    psv_q <= 1'b1;
    cyc(2);
    check(addr, 8'h2c);
    @(posedge ref_clk);
    svc_q <= 1'b0;
    cyc(2);
    check(addr, 8'h38);
    @(posedge ref_clk);
    {rst_q, nmi_q, hf_q} <= 3'h7;
    cyc(2);
    check(addr, 8'h04);
    @(posedge ref_clk);
    rst_q <= 1'b0;
    cyc(2);
    check(addr, 8'h08);
    @(posedge ref_clk);
    nmi_q <= 1'b0;
    cyc(2);
    check(addr, 8'h0c);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(1);
    check(prio, 64'h0);
    t_map;
    t_hold;
    t_prio;
    t_core;
    conclude;
  end
  initial
  begin
    #100000;
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire
